/* pkg/tpts_defines.svh */
// timing constants, field widths and reset values for the tdm port timing selector
`ifndef TPTS_DEFINES_SVH
`define TPTS_DEFINES_SVH

`define TPTS_FRAME_RATE_KHZ     8
`define TPTS_FRAME_PERIOD_US    125
`define TPTS_SER_REF_LO_KHZ     4096
`define TPTS_SER_REF_HI_KHZ     8192
`define TPTS_PAR_CLK_MAX_KHZ    19440
`define TPTS_SYS_CLK_KHZ        250000
`define TPTS_SER_CLKS_LO        (`TPTS_SER_REF_LO_KHZ / `TPTS_FRAME_RATE_KHZ)
`define TPTS_SER_CLKS_HI        (`TPTS_SER_REF_HI_KHZ / `TPTS_FRAME_RATE_KHZ)
`define TPTS_PAR_BYTES_DEF      (`TPTS_PAR_CLK_MAX_KHZ / `TPTS_FRAME_RATE_KHZ)
`define TPTS_SYS_PER_PAR_CLK    (`TPTS_SYS_CLK_KHZ / `TPTS_PAR_CLK_MAX_KHZ)
`define TPTS_CNT_W              12
`define TPTS_CNT_RST            12'h000
`define TPTS_BYTE_RST           8'h00
`define TPTS_CTRL_RST           4'h0

`endif

/* pkg/tpts_pkg.sv */
// types shared by the tdm port timing selector
package tpts_pkg;

  typedef enum logic [1:0] {
    timing_mode_1 = 2'b00,
    timing_mode_2 = 2'b01,
    timing_mode_3 = 2'b10,
    timing_mode_4 = 2'b11
  } tpts_mode_type;

  typedef struct packed {
    logic        prev;
  } tpts_edge_state_type;

  typedef struct packed {
    logic        ser_pin_prev;
    logic        ser_idle;
    logic        ser_fmt;
    logic [11:0] ser_cnt;
    logic        ser_start;
    logic        ser_strobe;
    logic        spck;
    logic        spck_oe;
    logic        fp_out;
    logic        fp_oe;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_frame_prev;
    logic        rx_start;
    logic [11:0] rx_cnt;
    logic [7:0]  tx_data;
    logic [3:0]  tx_ctrl;
    logic [11:0] tx_cnt;
    logic        tx_strobe;
    logic        tx_start;
    logic        ptf_out;
    logic        ptf_oe;
    logic        ptf_in_prev;
  } tpts_state_type;

endpackage

/* design/tpts_edge_det.sv */
// edge detector for a clock-like input sampled on the system clock
`timescale 1ns/10ps
module tpts_edge_det (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);

  tpts_pkg::tpts_edge_state_type state_r;
  tpts_pkg::tpts_edge_state_type state_nxt;

  always_comb begin
    state_nxt      = state_r;
    state_nxt.prev = sig;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rise = sig & ~state_r.prev;
  assign fall = ~sig & state_r.prev;

endmodule // tpts_edge_det

/* design/tpts_top.sv */
// timing mode clock and frame source selection for the serial and parallel tdm ports
// Notes on behaviour
// - serial frame pulse recurs at 8 kHz, one per 125 us serial frame
// - mode 1: frame pin is input, polarity sensed, port adapts to it
// - mode 2 with direction input: frame pin input, polarity from polarity control
// - mode 2 driving, and mode 3: frame pulse driven, aligned to port clock
// - mode 4: serial frame pin neither driven nor sampled
// - reference select low makes clock reference two active, 4.096 or 8.192 MHz
// - reference two ignored when reference select or internal clock select high
// - control lines carry connection memory control bits at parallel byte rate
// - transmit bytes leave on the parallel data outputs, up to 19.44 Mbyte/s
// - transmit frame pin is normally an output marking each frame start
// - direction input set: transmit frame pin taken from a peer device
// - transmit frame pin used in every mode except mode 3
// - receive clock from far end clocks in receive data and frame
// - modes 2, 3, 4 clock both parallel directions from the receive clock
// - mode 1 clocks transmit outputs on transmit clock; otherwise it is ignored
// - mode 3: receive frame pulse is frame reference for both parallel directions
// - modes 2 and 3 output a 4.096 MHz port clock from the selected reference
// - mode 1 or 8.192 MHz: data shifts directly on selected reference
`timescale 1ns/10ps
`include "tpts_defines.svh"
module tpts_top #(
  parameter logic [11:0] PAR_FRAME_BYTES = 12'(`TPTS_PAR_BYTES_DEF)
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [1:0]  TIMING_MODE,
  input  wire logic        SERIAL_FRAME_DIR_INPUT,
  input  wire logic        SERIAL_FRAME_POLARITY,
  input  wire logic        REF_SELECT_BIT,
  input  wire logic        INTERNAL_CLOCK_SELECT,
  input  wire logic        SERIAL_RATE_8M,
  input  wire logic        PAR_FRAME_DIR_INPUT,
  input  wire logic        SERIAL_CLOCK_REF_1,
  input  wire logic        SERIAL_CLOCK_REF_2,
  input  wire logic        INTERNAL_CLOCK_REF,
  input  wire logic        SERIAL_FRAME_PULSE_IN,
  output logic             SERIAL_FRAME_PULSE_OUT,
  output logic             SERIAL_FRAME_PULSE_OE,
  output logic             SERIAL_PORT_CLOCK_OUT,
  output logic             SERIAL_PORT_CLOCK_OE,
  output logic             SERIAL_SHIFT_STROBE,
  output logic             SERIAL_FRAME_START,
  output logic             SERIAL_FRAME_FORMAT,
  output logic [11:0]      SERIAL_BIT_COUNT,
  input  wire logic        PAR_RX_CLOCK,
  input  wire logic        PAR_TX_CLOCK,
  input  wire logic        PAR_RX_FRAME,
  input  wire logic [7:0]  PAR_DATA_IN,
  output logic [7:0]       PAR_RX_DATA,
  output logic             PAR_RX_VALID,
  output logic             PAR_RX_FRAME_START,
  output logic [11:0]      PAR_RX_COUNT,
  input  wire logic [7:0]  TX_BYTE,
  input  wire logic [3:0]  TX_CTRL_BITS,
  output logic             PAR_TX_STROBE,
  output logic             PAR_TX_FRAME_START,
  output logic [11:0]      PAR_TX_COUNT,
  output logic [7:0]       PAR_DATA_OUT,
  output logic [3:0]       EXT_CONTROL_LINES,
  input  wire logic        PAR_TX_FRAME_IN,
  output logic             PAR_TX_FRAME_OUT,
  output logic             PAR_TX_FRAME_OE
);

  localparam logic [11:0] SER_LAST_LO = 12'(`TPTS_SER_CLKS_LO - 1);
  localparam logic [11:0] SER_LAST_HI = 12'(`TPTS_SER_CLKS_HI - 1);
  localparam logic [11:0] PAR_LAST    = PAR_FRAME_BYTES - 12'h001;

  tpts_pkg::tpts_state_type state_r;
  tpts_pkg::tpts_state_type state_nxt;
  tpts_pkg::tpts_mode_type  mode;

  logic        ser_ref;
  logic        ser_rise;
  logic        ser_fall;
  logic        rx_rise;
  logic        tx_clk_sel;
  logic        tx_rise;

  // counter step with wrap at the last position of a frame
  function automatic logic [11:0] inc_wrap(input logic [11:0] cnt, input logic [11:0] last);
    logic [11:0] res;
    res = 12'h000;
    if (cnt >= last) begin
      res = 12'h000;
    end else begin
      res = cnt + 12'h001;
    end
    return res;
  endfunction

  assign mode = tpts_pkg::tpts_mode_type'(TIMING_MODE);

  // serial reference choice: internal, reference one, or reference two
  always_comb begin
    if (INTERNAL_CLOCK_SELECT) begin
      ser_ref = INTERNAL_CLOCK_REF;
    end else if (REF_SELECT_BIT) begin
      ser_ref = SERIAL_CLOCK_REF_1;
    end else begin
      ser_ref = SERIAL_CLOCK_REF_2;
    end
  end

  // transmit parallel clock: own clock in mode 1, receive clock otherwise
  always_comb begin
    if (mode == tpts_pkg::timing_mode_1) begin
      tx_clk_sel = PAR_TX_CLOCK;
    end else begin
      tx_clk_sel = PAR_RX_CLOCK;
    end
  end

  tpts_edge_det u_ser_edge (
    .clk  (SYS_CLK),
    .rst  (RST),
    .sig  (ser_ref),
    .rise (ser_rise),
    .fall (ser_fall)
  );

  tpts_edge_det u_rx_edge (
    .clk  (SYS_CLK),
    .rst  (RST),
    .sig  (PAR_RX_CLOCK),
    .rise (rx_rise),
    .fall ()
  );

  tpts_edge_det u_tx_edge (
    .clk  (SYS_CLK),
    .rst  (RST),
    .sig  (tx_clk_sel),
    .rise (tx_rise),
    .fall ()
  );

  always_comb begin
    logic        fp_in_mode;
    logic        fp_drive;
    logic        fp_pol;
    logic        fp_edge;
    logic        pin;
    logic [11:0] ser_last;
    logic        rx_edge;
    logic        tx_ref_edge;
    logic        tx_own_frame;
    logic [11:0] tx_next;

    fp_in_mode   = 1'b0;
    fp_drive     = 1'b0;
    fp_pol       = 1'b0;
    fp_edge      = 1'b0;
    pin          = SERIAL_FRAME_PULSE_IN;
    ser_last     = SERIAL_RATE_8M ? SER_LAST_HI : SER_LAST_LO;
    rx_edge      = 1'b0;
    tx_ref_edge  = 1'b0;
    tx_own_frame = 1'b0;
    tx_next      = 12'h000;
    state_nxt    = state_r;

    state_nxt.ser_start  = 1'b0;
    state_nxt.ser_strobe = 1'b0;
    state_nxt.rx_valid   = 1'b0;
    state_nxt.rx_start   = 1'b0;
    state_nxt.tx_strobe  = 1'b0;
    state_nxt.tx_start   = 1'b0;

    // serial frame pin direction and expected polarity per mode
    unique case (mode)
      tpts_pkg::timing_mode_1: begin
        fp_in_mode = 1'b1;
        fp_pol     = ~state_r.ser_idle;
      end
      tpts_pkg::timing_mode_2: begin
        fp_in_mode = SERIAL_FRAME_DIR_INPUT;
        fp_drive   = ~SERIAL_FRAME_DIR_INPUT;
        fp_pol     = SERIAL_FRAME_POLARITY;
      end
      tpts_pkg::timing_mode_3: begin
        fp_drive = 1'b1;
        fp_pol   = SERIAL_FRAME_POLARITY;
      end
      tpts_pkg::timing_mode_4: begin
        fp_in_mode = 1'b0;
        fp_drive   = 1'b0;
      end
    endcase

    // serial side: count, start, strobe and frame pulse advance on the selected reference; format and drive follow the mode
    if (ser_rise) begin
      if (fp_in_mode) begin
        state_nxt.ser_pin_prev = pin;
        if (pin == state_r.ser_pin_prev) begin
          state_nxt.ser_idle = pin;
        end
        fp_edge = (pin == fp_pol) && (state_r.ser_pin_prev != fp_pol);
      end
      if (fp_edge) begin
        state_nxt.ser_cnt = 12'h000;
      end else begin
        state_nxt.ser_cnt = inc_wrap(state_r.ser_cnt, ser_last);
      end
      state_nxt.ser_start = fp_edge | (~fp_in_mode & (state_r.ser_cnt >= ser_last));
      state_nxt.fp_out    = ((state_r.ser_cnt + 12'h001) >= ser_last) ? fp_pol : ~fp_pol;
    end
    if (ser_fall) begin
      state_nxt.ser_strobe = 1'b1;
    end
    state_nxt.ser_fmt = fp_pol;
    state_nxt.fp_oe   = fp_drive;
    if (!fp_drive) begin
      state_nxt.fp_out = 1'b0;
    end

    // port clock out only in modes 2 and 3 at the 4.096 MHz rate
    if ((mode == tpts_pkg::timing_mode_2 || mode == tpts_pkg::timing_mode_3) && !SERIAL_RATE_8M) begin
      state_nxt.spck_oe = 1'b1;
      state_nxt.spck    = ser_ref;
    end else begin
      state_nxt.spck_oe = 1'b0;
      state_nxt.spck    = 1'b0;
    end

    // receive parallel port: byte and frame sampled on the receive clock
    if (rx_rise) begin
      state_nxt.rx_data       = PAR_DATA_IN;
      state_nxt.rx_valid      = 1'b1;
      state_nxt.rx_frame_prev = PAR_RX_FRAME;
      rx_edge                 = PAR_RX_FRAME & ~state_r.rx_frame_prev;
      if (rx_edge) begin
        state_nxt.rx_cnt   = 12'h000;
        state_nxt.rx_start = 1'b1;
      end else begin
        state_nxt.rx_cnt = inc_wrap(state_r.rx_cnt, PAR_LAST);
      end
    end

    // transmit parallel frame reference per mode and pin direction
    if (mode == tpts_pkg::timing_mode_3) begin
      tx_ref_edge = rx_rise & rx_edge;
    end else if (PAR_FRAME_DIR_INPUT) begin
      tx_ref_edge = tx_rise & PAR_TX_FRAME_IN & ~state_r.ptf_in_prev;
    end else begin
      tx_own_frame = 1'b1;
    end
    if (tx_rise) begin
      state_nxt.ptf_in_prev = PAR_TX_FRAME_IN & PAR_FRAME_DIR_INPUT & (mode != tpts_pkg::timing_mode_3);
    end

    // transmit parallel port: byte, control lines and frame marker per clock
    if (tx_rise) begin
      state_nxt.tx_data   = TX_BYTE;
      state_nxt.tx_ctrl   = TX_CTRL_BITS;
      state_nxt.tx_strobe = 1'b1;
      if (tx_ref_edge) begin
        tx_next = 12'h000;
      end else begin
        tx_next = inc_wrap(state_r.tx_cnt, PAR_LAST);
      end
      state_nxt.tx_cnt   = tx_next;
      state_nxt.tx_start = (tx_next == 12'h000);
      state_nxt.ptf_out  = tx_own_frame & (tx_next == 12'h000);
    end
    state_nxt.ptf_oe = tx_own_frame & (mode != tpts_pkg::timing_mode_3);
    if (!state_nxt.ptf_oe) begin
      state_nxt.ptf_out = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r         <= '0;
      state_r.ser_cnt <= `TPTS_CNT_RST;
      state_r.rx_cnt  <= `TPTS_CNT_RST;
      state_r.tx_cnt  <= `TPTS_CNT_RST;
      state_r.rx_data <= `TPTS_BYTE_RST;
      state_r.tx_data <= `TPTS_BYTE_RST;
      state_r.tx_ctrl <= `TPTS_CTRL_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign SERIAL_FRAME_PULSE_OUT = state_r.fp_out;
  assign SERIAL_FRAME_PULSE_OE  = state_r.fp_oe;
  assign SERIAL_PORT_CLOCK_OUT  = state_r.spck;
  assign SERIAL_PORT_CLOCK_OE   = state_r.spck_oe;
  assign SERIAL_SHIFT_STROBE    = state_r.ser_strobe;
  assign SERIAL_FRAME_START     = state_r.ser_start;
  assign SERIAL_FRAME_FORMAT    = state_r.ser_fmt;
  assign SERIAL_BIT_COUNT       = state_r.ser_cnt;
  assign PAR_RX_DATA            = state_r.rx_data;
  assign PAR_RX_VALID           = state_r.rx_valid;
  assign PAR_RX_FRAME_START     = state_r.rx_start;
  assign PAR_RX_COUNT           = state_r.rx_cnt;
  assign PAR_TX_STROBE          = state_r.tx_strobe;
  assign PAR_TX_FRAME_START     = state_r.tx_start;
  assign PAR_TX_COUNT           = state_r.tx_cnt;
  assign PAR_DATA_OUT           = state_r.tx_data;
  assign EXT_CONTROL_LINES      = state_r.tx_ctrl;
  assign PAR_TX_FRAME_OUT       = state_r.ptf_out;
  assign PAR_TX_FRAME_OE        = state_r.ptf_oe;

endmodule // tpts_top

/* verification/tpts_top_sva.sv */
// assertion checker for the tdm port timing selector
`timescale 1ns/10ps
module tpts_top_sva (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [1:0]  TIMING_MODE,
  input wire logic        SERIAL_FRAME_DIR_INPUT,
  input wire logic        SERIAL_FRAME_POLARITY,
  input wire logic        SERIAL_RATE_8M,
  input wire logic        PAR_FRAME_DIR_INPUT,
  input wire logic        PAR_RX_CLOCK,
  input wire logic        PAR_TX_CLOCK,
  input wire logic        PAR_RX_FRAME,
  input wire logic [7:0]  PAR_DATA_IN,
  input wire logic [7:0]  TX_BYTE,
  input wire logic [3:0]  TX_CTRL_BITS,
  input wire logic        SERIAL_FRAME_PULSE_OUT,
  input wire logic        SERIAL_FRAME_PULSE_OE,
  input wire logic        SERIAL_PORT_CLOCK_OUT,
  input wire logic        SERIAL_PORT_CLOCK_OE,
  input wire logic        SERIAL_FRAME_START,
  input wire logic        SERIAL_FRAME_FORMAT,
  input wire logic [11:0] SERIAL_BIT_COUNT,
  input wire logic [7:0]  PAR_RX_DATA,
  input wire logic        PAR_RX_VALID,
  input wire logic [11:0] PAR_RX_COUNT,
  input wire logic        PAR_TX_STROBE,
  input wire logic [7:0]  PAR_DATA_OUT,
  input wire logic [3:0]  EXT_CONTROL_LINES,
  input wire logic        PAR_TX_FRAME_OE,
  input wire logic        PAR_TX_FRAME_OUT,
  input wire logic [11:0] PAR_TX_COUNT
);
  logic [1:0] live_r;
  logic       taken_r;
  logic       stable_r;
  logic       m1, m2, m3, spck_want, ptf_want;
  assign m1 = TIMING_MODE == tpts_pkg::timing_mode_1;
  assign m2 = TIMING_MODE == tpts_pkg::timing_mode_2;
  assign m3 = TIMING_MODE == tpts_pkg::timing_mode_3;
  assign spck_want = (m2 || m3) && !SERIAL_RATE_8M;
  assign ptf_want = !PAR_FRAME_DIR_INPUT && !m3;
  // cycles since reset, the taken transmit edge and mode steadiness
  always_ff @(posedge SYS_CLK) begin
    live_r   <= RST ? 2'h0 : ((live_r == 2'h3) ? live_r : live_r + 2'h1);
    taken_r  <= m1 ? $rose(PAR_TX_CLOCK) : $rose(PAR_RX_CLOCK);
    stable_r <= $stable(TIMING_MODE);
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST || live_r != 2'h3);
  sequence s_rx_rise;
    $rose(PAR_RX_CLOCK);
  endsequence
  sequence s_rx_frame_edge;
    s_rx_rise ##0 PAR_RX_FRAME;
  endsequence
  AST_SER_FP_DRIVE: assert property ((m3 || (m2 && !SERIAL_FRAME_DIR_INPUT)) |=> SERIAL_FRAME_PULSE_OE)
    else $error("serial frame pin not driven");
  AST_SER_FP_UNUSED: assert property ((!m3 && !(m2 && !SERIAL_FRAME_DIR_INPUT)) |=> !SERIAL_FRAME_PULSE_OE)
    else $error("serial frame pin driven while input or unused");
  AST_SER_FP_QUIET: assert property (!SERIAL_FRAME_PULSE_OE |-> !SERIAL_FRAME_PULSE_OUT)
    else $error("serial frame level high while not driven");
  AST_SER_FMT: assert property ((m2 || m3) |=> SERIAL_FRAME_FORMAT == $past(SERIAL_FRAME_POLARITY))
    else $error("serial frame format differs from polarity control");
  AST_SPCK_OE: assert property (1'b1 |=> SERIAL_PORT_CLOCK_OE == $past(spck_want))
    else $error("port clock enable wrong for mode");
  AST_SPCK_QUIET: assert property (!SERIAL_PORT_CLOCK_OE |-> !SERIAL_PORT_CLOCK_OUT)
    else $error("port clock toggles while disabled");
  AST_SER_START: assert property (SERIAL_FRAME_START |-> SERIAL_BIT_COUNT == 12'h000)
    else $error("serial frame start away from count zero");
  AST_RX_CAPTURE: assert property (s_rx_rise |=> PAR_RX_VALID && PAR_RX_DATA == $past(PAR_DATA_IN))
    else $error("receive byte not captured on receive clock rise");
  AST_RX_ALIGN: assert property (s_rx_frame_edge |=> PAR_RX_COUNT == 12'h000)
    else $error("receive count not realigned at frame");
  AST_TX_STROBE: assert property (stable_r |-> PAR_TX_STROBE == taken_r)
    else $error("transmit byte taken on wrong clock");
  AST_TX_DATA: assert property (taken_r |-> PAR_DATA_OUT == $past(TX_BYTE) && EXT_CONTROL_LINES == $past(TX_CTRL_BITS))
    else $error("transmit byte or control lines wrong");
  AST_TX_FRAME_OE: assert property (1'b1 |=> PAR_TX_FRAME_OE == $past(ptf_want))
    else $error("transmit frame pin direction wrong");
  AST_TX_FRAME_MARK: assert property ((PAR_TX_STROBE && PAR_TX_FRAME_OE) |-> PAR_TX_FRAME_OUT == (PAR_TX_COUNT == 12'h000))
    else $error("transmit frame marker not at byte zero");
endmodule // tpts_top_sva

bind tpts_top tpts_top_sva i_tpts_top_sva (.*);

/* verification/tpts_far_end.sv */
// far end framer model: receive clock, transmit clock, frame pulse and bytes
`timescale 1ns/10ps
module tpts_far_end #(
  parameter int RX_HALF   = 3,
  parameter int TX_HALF   = 4,
  parameter int FRAME_LEN = 6
) (
  input  wire logic  clk,
  output logic       rx_clk,
  output logic       tx_clk,
  output logic       rx_frame,
  output logic [7:0] rx_data
);
  int rx_ph = 0;
  int tx_ph = 0;
  int byte_no = 0;
  initial begin
    rx_clk = 1'b0;
    tx_clk = 1'b0;
    rx_frame = 1'b0;
    rx_data = 8'h00;
  end
  // new byte and frame marker set up on the falling half of the receive clock
  always @(negedge clk) begin
    rx_ph <= (rx_ph == RX_HALF - 1) ? 0 : rx_ph + 1;
    tx_ph <= (tx_ph == TX_HALF - 1) ? 0 : tx_ph + 1;
    if (tx_ph == TX_HALF - 1) tx_clk <= ~tx_clk;
    if (rx_ph == RX_HALF - 1) begin
      rx_clk <= ~rx_clk;
      if (rx_clk) begin
        byte_no <= (byte_no == FRAME_LEN - 1) ? 0 : byte_no + 1;
        rx_frame <= byte_no == FRAME_LEN - 1;
        rx_data <= rx_data + 8'h1d;
      end
    end
  end
endmodule // tpts_far_end

/* verification/tdm_port_timing_select_tb.sv */
// self-checking testbench for the tdm port timing selector
`timescale 1ns/10ps
module tdm_port_timing_select_tb;
  logic SYS_CLK, RST, SERIAL_FRAME_DIR_INPUT, SERIAL_FRAME_POLARITY, REF_SELECT_BIT, INTERNAL_CLOCK_SELECT;
  logic SERIAL_RATE_8M, PAR_FRAME_DIR_INPUT, SERIAL_CLOCK_REF_1, SERIAL_CLOCK_REF_2, INTERNAL_CLOCK_REF;
  logic SERIAL_FRAME_PULSE_IN, PAR_RX_CLOCK, PAR_TX_CLOCK, PAR_RX_FRAME, SERIAL_FRAME_PULSE_OE;
  logic SERIAL_SHIFT_STROBE, SERIAL_FRAME_START, SERIAL_FRAME_FORMAT, PAR_RX_FRAME_START;
  logic PAR_TX_STROBE, PAR_TX_FRAME_START, run1, run2, runi;
  logic [1:0] TIMING_MODE, dv;
  logic [7:0] PAR_DATA_IN, TX_BYTE;
  logic [3:0] TX_CTRL_BITS;
  int         n_fail, check_count;
  tpts_top #(.PAR_FRAME_BYTES(12'h008)) i_tpts_top (.SYS_CLK, .RST, .TIMING_MODE, .SERIAL_FRAME_DIR_INPUT,
    .SERIAL_FRAME_POLARITY, .REF_SELECT_BIT, .INTERNAL_CLOCK_SELECT, .SERIAL_RATE_8M, .PAR_FRAME_DIR_INPUT,
    .SERIAL_CLOCK_REF_1, .SERIAL_CLOCK_REF_2, .INTERNAL_CLOCK_REF, .SERIAL_FRAME_PULSE_IN,
    .SERIAL_FRAME_PULSE_OUT(), .SERIAL_FRAME_PULSE_OE, .SERIAL_PORT_CLOCK_OUT(), .SERIAL_PORT_CLOCK_OE(),
    .SERIAL_SHIFT_STROBE, .SERIAL_FRAME_START, .SERIAL_FRAME_FORMAT, .SERIAL_BIT_COUNT(), .PAR_RX_CLOCK,
    .PAR_TX_CLOCK, .PAR_RX_FRAME, .PAR_DATA_IN, .PAR_RX_DATA(), .PAR_RX_VALID(), .PAR_RX_FRAME_START,
    .PAR_RX_COUNT(), .TX_BYTE, .TX_CTRL_BITS, .PAR_TX_STROBE, .PAR_TX_FRAME_START, .PAR_TX_COUNT(),
    .PAR_DATA_OUT(), .EXT_CONTROL_LINES(), .PAR_TX_FRAME_IN(PAR_RX_FRAME), .PAR_TX_FRAME_OUT(),
    .PAR_TX_FRAME_OE());
  tpts_far_end i_tpts_far_end (.clk(SYS_CLK), .rx_clk(PAR_RX_CLOCK), .tx_clk(PAR_TX_CLOCK),
    .rx_frame(PAR_RX_FRAME), .rx_data(PAR_DATA_IN));
  always #2 SYS_CLK = ~SYS_CLK;
  // serial references, each level two system clocks; next transmit byte after each take
  always @(negedge SYS_CLK) begin
    dv <= dv + 2'h1;
    SERIAL_CLOCK_REF_1 <= run1 & dv[1];
    SERIAL_CLOCK_REF_2 <= run2 & dv[1];
    INTERNAL_CLOCK_REF <= runi & dv[1];
    if (PAR_TX_STROBE === 1'b1) begin
      TX_BYTE <= TX_BYTE + 8'h35;
      TX_CTRL_BITS <= TX_CTRL_BITS + 4'h1;
    end
  end
  function automatic logic pick(input int s);
    return (s == 0) ? PAR_TX_FRAME_START : ((s == 1) ? PAR_RX_FRAME_START : SERIAL_FRAME_START);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cycles between two consecutive start pulses, after skipping the settling one and one full period
  task automatic measure(input int s, output int p);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin @(negedge SYS_CLK); p++; end while (pick(s) !== 1'b1 && p < 9000);
    end
  endtask
  task automatic par_case(input logic [1:0] m, input logic dir, input int per);
    int p;
    @(negedge SYS_CLK);
    TIMING_MODE = m;
    PAR_FRAME_DIR_INPUT = dir;
    measure(0, p);
    chk(p, per);
    measure(1, p);
    chk(p, 36);
    $display("parallel test done mode=%0d dir=%0d", m, dir);
  endtask
  task automatic ref_case(input logic sel, isel, r1, r2, ri, exp);
    int n;
    n = 0;
    @(negedge SYS_CLK);
    REF_SELECT_BIT = sel;
    INTERNAL_CLOCK_SELECT = isel;
    {run1, run2, runi} = {r1, r2, ri};
    repeat (8) @(negedge SYS_CLK);
    repeat (100) begin @(negedge SYS_CLK); if (SERIAL_SHIFT_STROBE === 1'b1) n++; end
    chk(n != 0, exp);
    $display("reference test done sel=%0d int=%0d", sel, isel);
  endtask
  task automatic ser_case(input logic [1:0] m, input logic dir, pol, pin, rate, input int per, input logic oe, fmt);
    int p;
    @(negedge SYS_CLK);
    {TIMING_MODE, SERIAL_FRAME_DIR_INPUT, SERIAL_FRAME_POLARITY} = {m, dir, pol};
    {SERIAL_FRAME_PULSE_IN, SERIAL_RATE_8M} = {pin, rate};
    if (per > 0) begin measure(2, p); chk(p, per); end
    else repeat (200) @(negedge SYS_CLK);
    chk(SERIAL_FRAME_FORMAT, fmt);
    chk(SERIAL_FRAME_PULSE_OE, oe);
    $display("serial test done mode=%0d dir=%0d pol=%0d", m, dir, pol);
  endtask
  initial begin
    {RST, TIMING_MODE, SERIAL_FRAME_DIR_INPUT, SERIAL_FRAME_POLARITY, SERIAL_RATE_8M} = {1'b1, 2'b01, 3'b000};
    {REF_SELECT_BIT, INTERNAL_CLOCK_SELECT, PAR_FRAME_DIR_INPUT, SERIAL_FRAME_PULSE_IN} = 4'b1001;
    {SERIAL_CLOCK_REF_1, SERIAL_CLOCK_REF_2, INTERNAL_CLOCK_REF, run1, run2, runi} = 6'b000100;
    {SYS_CLK, dv, TX_BYTE, TX_CTRL_BITS, n_fail, check_count} = '0;
    repeat (12) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST = 1'b0;
    par_case(2'b01, 1'b0, 48);
    par_case(2'b01, 1'b1, 36);
    par_case(2'b10, 1'b0, 36);
    par_case(2'b00, 1'b0, 64);
    par_case(2'b11, 1'b0, 48);
    ref_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    ref_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    ref_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    ref_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    ref_case(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ref_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    ser_case(2'b00, 1'b0, 1'b1, 1'b1, 1'b0, 0, 1'b0, 1'b0);
    ser_case(2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    ser_case(2'b01, 1'b1, 1'b1, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    ser_case(2'b01, 1'b1, 1'b0, 1'b1, 1'b0, 0, 1'b0, 1'b0);
    ser_case(2'b10, 1'b0, 1'b0, 1'b1, 1'b0, 2048, 1'b1, 1'b0);
    ser_case(2'b10, 1'b0, 1'b1, 1'b0, 1'b0, 2048, 1'b1, 1'b1);
    ser_case(2'b01, 1'b0, 1'b1, 1'b0, 1'b0, 2048, 1'b1, 1'b1);
    ser_case(2'b10, 1'b0, 1'b1, 1'b0, 1'b1, 4096, 1'b1, 1'b1);
    stop_test();
  end
  // watchdog: the tests need about 32000 cycles
  initial begin
    #240000;
    n_fail++;
    stop_test();
  end
endmodule // tdm_port_timing_select_tb
